// ### eie_top.sv
`timescale 1ns/1ps
module eie_top
   import eie_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       ext_request_pin3,
   input  wire logic       ext_request_pin0,
   input  wire logic [5:0] wake_pin,
   input  wire logic       pin3_is_irq,
   input  wire logic       pin0_is_irq,
   input  wire logic [5:0] wake_is_irq,
   input  wire logic       sleep_direct_transition,
   input  wire logic       direct_transition_control,
   input  wire logic       cpu_int_mask,
   output logic            req_pin3,
   output logic            req_pin0,
   output logic            req_wake,
   output logic            req_direct_transition,
   output logic            irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] edge1_reg;
   logic [7:0] edge2_reg;
   logic [7:0] enable_reg;
   logic [7:0] rflag_reg;
   logic [7:0] wflag_reg;
   logic [EIE_NEVT-1:0] istat_reg;
   logic [EIE_NEVT-1:0] imask_reg;
   logic [7:0] rflag_next;
   logic [7:0] wflag_next;
   logic [7:0] rflag_set;
   logic [7:0] wflag_set;
   logic [7:0] rdata_next;
   logic [EIE_NEVT-1:0] evt;
   logic       hit3;
   logic       hit0;
   logic [EIE_NWAKE-1:0] hitw;
   logic       req3_c;
   logic       req0_c;
   logic       reqw_c;
   logic       reqdt_c;

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection
   eie_edge_det u_det3 (
      .mclk       (mclk),
      .rst        (rst),
      .pin        (ext_request_pin3),
      .rising_sel (edge1_reg[EIE_BIT_PIN3]),
      .edge_hit   (hit3)
   );

   eie_edge_det u_det0 (
      .mclk       (mclk),
      .rst        (rst),
      .pin        (ext_request_pin0),
      .rising_sel (edge1_reg[EIE_BIT_PIN0]),
      .edge_hit   (hit0)
   );

   // Wake pin 5 is also the converter trigger; same polarity bit serves both
   genvar gi;
   generate
      for (gi = 0; gi < EIE_NWAKE; gi++) begin : g_wake
         eie_edge_det u_detw (
            .mclk       (mclk),
            .rst        (rst),
            .pin        (wake_pin[gi]),
            .rising_sel (edge2_reg[gi]),
            .edge_hit   (hitw[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         edge1_reg <= EIE_EDGE1_FIX;
      end else if (wr && addr == EIE_OFS_EDGE1) begin
         edge1_reg <= (wdata & EIE_EDGE1_RW) | EIE_EDGE1_FIX;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         edge2_reg <= EIE_EDGE2_FIX;
      end else if (wr && addr == EIE_OFS_EDGE2) begin
         edge2_reg <= (wdata & EIE_EDGE2_RW) | EIE_EDGE2_FIX;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         enable_reg <= EIE_EN_FIX;
      end else if (wr && addr == EIE_OFS_ENABLE) begin
         enable_reg <= (wdata & EIE_EN_RW) | EIE_EN_FIX;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         imask_reg <= '0;
      end else if (wr && addr == EIE_OFS_IMASK) begin
         imask_reg <= wdata[EIE_NEVT-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request flags: set wins over a write of 0 in the same cycle
   always_comb begin
      rflag_set = EIE_RESET_ZERO;
      rflag_set[EIE_BIT_PIN3] = hit3 & pin3_is_irq;
      rflag_set[EIE_BIT_PIN0] = hit0 & pin0_is_irq;
      rflag_set[EIE_BIT_DT] = sleep_direct_transition & direct_transition_control;
      rflag_next = rflag_reg;
      if (wr && addr == EIE_OFS_RFLAG) begin
         // Only writing 0 clears; writing 1 keeps the flag
         rflag_next = rflag_reg & (wdata | ~EIE_RF_RW);
      end
      rflag_next = (rflag_next | rflag_set) & EIE_RF_RW | EIE_RF_FIX;
   end

   always_comb begin
      wflag_set = EIE_RESET_ZERO;
      wflag_set[EIE_NWAKE-1:0] = hitw & wake_is_irq;
      wflag_next = wflag_reg;
      if (wr && addr == EIE_OFS_WFLAG) begin
         wflag_next = wflag_reg & (wdata | ~EIE_WF_RW);
      end
      wflag_next = (wflag_next | wflag_set) & EIE_WF_RW | EIE_WF_FIX;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rflag_reg <= EIE_RF_FIX;
         wflag_reg <= EIE_WF_FIX;
      end else begin
         rflag_reg <= rflag_next;
         wflag_reg <= wflag_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Requests to the CPU: flag and enable, then the CPU mask
   always_comb begin
      req3_c  = rflag_reg[EIE_BIT_PIN3] & enable_reg[EIE_BIT_PIN3] & ~cpu_int_mask;
      req0_c  = rflag_reg[EIE_BIT_PIN0] & enable_reg[EIE_BIT_PIN0] & ~cpu_int_mask;
      reqw_c  = (|wflag_reg[EIE_NWAKE-1:0]) & enable_reg[EIE_BIT_WAKE] & ~cpu_int_mask;
      reqdt_c = rflag_reg[EIE_BIT_DT] & enable_reg[EIE_BIT_DT] & ~cpu_int_mask;
   end

   // Registered so outputs come from flops; a request that rose before a clear
   // is thus still presented one cycle later and taken after the clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         req_pin3              <= 1'b0;
         req_pin0              <= 1'b0;
         req_wake              <= 1'b0;
         req_direct_transition <= 1'b0;
      end else begin
         req_pin3              <= req3_c;
         req_pin0              <= req0_c;
         req_wake              <= reqw_c;
         req_direct_transition <= reqdt_c;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event status, cleared by read; set wins over the read clear
   always_comb begin
      evt = {rflag_set[EIE_BIT_DT], |wflag_set, rflag_set[EIE_BIT_PIN3],
             rflag_set[EIE_BIT_PIN0]};
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         istat_reg <= '0;
      end else if (rd && addr == EIE_OFS_ISTAT) begin
         istat_reg <= evt;
      end else begin
         istat_reg <= istat_reg | evt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_reg & imask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data stand in the cycle after the strobe, zero otherwise
   always_comb begin
      rdata_next = EIE_RESET_ZERO;
      case (addr)
         EIE_OFS_EDGE1:  rdata_next = edge1_reg;
         EIE_OFS_EDGE2:  rdata_next = edge2_reg;
         EIE_OFS_ENABLE: rdata_next = enable_reg;
         EIE_OFS_RFLAG:  rdata_next = rflag_reg;
         EIE_OFS_WFLAG:  rdata_next = wflag_reg;
         EIE_OFS_ISTAT:  rdata_next = {{(8-EIE_NEVT){1'b0}}, istat_reg};
         EIE_OFS_IMASK:  rdata_next = {{(8-EIE_NEVT){1'b0}}, imask_reg};
         default:        rdata_next = EIE_RESET_ZERO;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= EIE_RESET_ZERO;
      end else if (rd) begin
         rdata <= rdata_next;
      end else begin
         rdata <= EIE_RESET_ZERO;
      end
   end
endmodule // eie_top

// ### eie_pkg.sv
// Functional notes
// - Bit 3 of the request pin edge register picks falling (0) or rising (1) edges on pin 3.
// - Bit 0 of the request pin edge register picks falling (0) or rising (1) edges on pin 0.
// - Bits 5 to 0 of the wakeup edge register pick falling (0) or rising (1) per wakeup pin.
// - The bit 5 wakeup edge choice also applies to the shared converter trigger pin.
// - Reserved bits of both edge registers read as fixed constants and ignore writes.
// - Bit 7 of the enable register enables direct transition requests, reset 0.
// - Bit 5 of the enable register is one common enable for all six wakeup pins.
// - Bits 3 and 0 of the enable register enable pins 3 and 0, both reset 0.
// - Reserved bits of the enable register read 0 at bit 6, 1 at bit 4, 0 at bits 2 to 1.
// - A request colliding with a clear of its enable or flag is still taken afterwards.
// - Pin 3 and pin 0 flags set on their selected edge and clear only by writing 0.
// - Each wakeup flag sets on its selected edge and clears by writing 0.
// - The direct transition flag sets on a sleep direct transition with the control bit 1.
// - While the CPU mask is 1, requests stay masked.
package eie_pkg;
   localparam logic [2:0] EIE_OFS_EDGE1  = 3'h0;
   localparam logic [2:0] EIE_OFS_EDGE2  = 3'h1;
   localparam logic [2:0] EIE_OFS_ENABLE = 3'h2;
   localparam logic [2:0] EIE_OFS_RFLAG  = 3'h3;
   localparam logic [2:0] EIE_OFS_WFLAG  = 3'h4;
   localparam logic [2:0] EIE_OFS_ISTAT  = 3'h5;
   localparam logic [2:0] EIE_OFS_IMASK  = 3'h6;
   // Edge register 1 layout
   localparam logic [7:0] EIE_EDGE1_RW   = 8'h09;
   localparam logic [7:0] EIE_EDGE1_FIX  = 8'h70;
   // Edge register 2 layout
   localparam logic [7:0] EIE_EDGE2_RW   = 8'h3f;
   localparam logic [7:0] EIE_EDGE2_FIX  = 8'hc0;
   // Enable register layout
   localparam logic [7:0] EIE_EN_RW      = 8'ha9;
   localparam logic [7:0] EIE_EN_FIX     = 8'h10;
   // Request flag register layout
   localparam logic [7:0] EIE_RF_RW      = 8'h89;
   localparam logic [7:0] EIE_RF_FIX     = 8'h30;
   // Wakeup flag register layout
   localparam logic [7:0] EIE_WF_RW      = 8'h3f;
   localparam logic [7:0] EIE_WF_FIX     = 8'hc0;
   localparam int         EIE_BIT_PIN0   = 0;
   localparam int         EIE_BIT_PIN3   = 3;
   localparam int         EIE_BIT_WAKE   = 5;
   localparam int         EIE_BIT_DT     = 7;
   localparam int         EIE_NWAKE      = 6;
   // Interrupt status bits: 0 pin0, 1 pin3, 2 wakeup, 3 direct transition
   localparam int         EIE_NEVT       = 4;
   localparam logic [7:0] EIE_RESET_ZERO = 8'h00;
endpackage

// ### eie_edge_det.sv
`timescale 1ns/1ps
module eie_edge_det (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic pin,
   input  wire logic rising_sel,
   output logic      edge_hit
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;

   // Two stages before any use; only sync2 is compared
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         prev_reg  <= 1'b1;
      end else begin
         sync1_reg <= pin;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   assign edge_hit = rising_sel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg);
endmodule // eie_edge_det

// ### eie_cpu_model.sv
`timescale 1ns/1ps
module eie_cpu_model (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic mask_cmd,
   input  wire logic irq,
   output logic      cpu_int_mask,
   output logic      taken
);
   // Mask held set through reset, as a core leaves reset masked
   always_ff @(posedge mclk) begin
      cpu_int_mask <= rst | mask_cmd;
   end
   always_ff @(posedge mclk) begin
      taken <= irq & ~cpu_int_mask & ~rst;
   end
endmodule // eie_cpu_model

// ### eie_top_assertions.sv
`timescale 1ns/1ps
module eie_chk
   import eie_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [2:0] addr,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       cpu_int_mask,
   input wire logic       req_pin0,
   input wire logic       req_wake
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_rd(logic [2:0] a);
      rd && addr == a;
   endsequence
   AST_EDGE1: assert property (s_rd(EIE_OFS_EDGE1) |=> (rdata & 8'hf6) == 8'h70)
      else $error("edge1 fixed bits");
   AST_EDGE2: assert property (s_rd(EIE_OFS_EDGE2) |=> rdata[7:6] == 2'b11)
      else $error("edge2 fixed bits");
   AST_ENABLE: assert property (s_rd(EIE_OFS_ENABLE) |=> (rdata & 8'h56) == 8'h10)
      else $error("enable fixed bits");
   AST_RFLAG: assert property (s_rd(EIE_OFS_RFLAG) |=> (rdata & 8'h76) == 8'h30)
      else $error("flag fixed bits");
   AST_WFLAG: assert property (s_rd(EIE_OFS_WFLAG) |=> rdata[7:6] == 2'b11)
      else $error("wake flag fixed bits");
   AST_IDLE: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside read");
   AST_MASK: assert property (cpu_int_mask |=> !req_pin0 && !req_wake)
      else $error("request while masked");
   AST_HOLD0: assert property (req_pin0 && !cpu_int_mask && !wr && !$past(wr) |=> req_pin0)
      else $error("pin0 request dropped");
   AST_HOLDW: assert property (req_wake && !cpu_int_mask && !wr && !$past(wr) |=> req_wake)
      else $error("wake request dropped");
endmodule // eie_chk
bind eie_top eie_chk i_chk (.mclk(mclk), .rst(rst), .addr(addr), .wr(wr), .rd(rd),
   .rdata(rdata), .cpu_int_mask(cpu_int_mask), .req_pin0(req_pin0), .req_wake(req_wake));

// ### eie_top_bench.sv
`timescale 1ns/1ps
module eie_top_bench;
   import eie_pkg::*;
   logic       mclk = 0, rst = 1, wr = 0, rd = 0, p3 = 1, p0 = 1, sdt = 0, dtc = 0, mcmd = 0;
   logic       cm, r3, r0, rw_k, rdt, irq, rd_seen = 0, look = 0, des = 1;
   logic [2:0] addr = 0;
   logic [7:0] wdata = 0, rdata, v;
   logic [5:0] wake = 6'h3f;
   logic [7:0] rv[8] = '{8'h70, 8'hc0, 8'h10, 8'h30, 8'hc0, 8'h00, 8'h00, 8'h00};
   logic [7:0] rwm[3] = '{EIE_EDGE1_RW, EIE_EDGE2_RW, EIE_EN_RW};
   logic [7:0] exp_q[$];
   logic [4:0] req_q[$];
   int         err_total, checks_done, cyc, k;
   eie_top i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ext_request_pin3(p3), .ext_request_pin0(p0), .wake_pin(wake),
      .pin3_is_irq(des), .pin0_is_irq(des), .wake_is_irq({6{des}}),
      .sleep_direct_transition(sdt), .direct_transition_control(dtc), .cpu_int_mask(cm),
      .req_pin3(r3), .req_pin0(r0), .req_wake(rw_k), .req_direct_transition(rdt), .irq(irq));
   eie_cpu_model i_cpu (.mclk(mclk), .rst(rst), .mask_cmd(mcmd), .irq(irq),
      .cpu_int_mask(cm), .taken());
   initial begin
      forever #5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(string what, logic [7:0] e, logic [7:0] got);
      checks_done++;
      if (got !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr_reg(logic [2:0] a, logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(logic [2:0] a, logic [7:0] e);
      @(posedge mclk);
      exp_q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
   endtask
   // Six edges cover the two sync stages, detect, flag and request
   task automatic want_req(logic [4:0] e);
      repeat (6) @(posedge mclk);
      req_q.push_back(e);
      look <= 1'b1;
      @(posedge mclk);
      look <= 1'b0;
   endtask
   task automatic pins(logic lv);
      @(posedge mclk);
      p3 <= lv;
      p0 <= lv;
      wake[k] <= lv;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      rd_seen <= rd;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         stop_test();
      end
   end
   always @(negedge mclk) begin
      if (rd_seen) cmp("rdata", exp_q.pop_front(), rdata);
      if (look) cmp("req", {3'h0, req_q.pop_front()}, {3'h0, irq, rdt, rw_k, r3, r0});
   end
   initial begin
      void'($urandom(32'h232c4171));
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rd_reg(i[2:0], rv[i]);
      for (int i = 0; i < 3; i++) begin
         v = 8'($urandom);
         wr_reg(i[2:0], v);
         rd_reg(i[2:0], (v & rwm[i]) | rv[i]);
      end
      wr_reg(3'h7, 8'hff);
      rd_reg(3'h7, 8'h00);
      wr_reg(EIE_OFS_ENABLE, 8'ha9);
      // Rising pass: wrong edge first, then the selected one; falling pass: pins already high, so only the selected edge; random wakeup pin
      for (int p = 1; p >= 0; p--) begin
         k = $urandom_range(5);
         wr_reg(EIE_OFS_EDGE1, p ? 8'h09 : 8'h00);
         wr_reg(EIE_OFS_EDGE2, p ? 8'h3f : 8'h00);
         pins(!p[0]);
         want_req(5'h00);
         pins(p[0]);
         want_req(5'h07);
         rd_reg(EIE_OFS_RFLAG, 8'h39);
         rd_reg(EIE_OFS_WFLAG, 8'hc0 | (8'h01 << k));
         mcmd <= 1'b1;
         want_req(5'h00);
         wr_reg(EIE_OFS_RFLAG, 8'h00);
         wr_reg(EIE_OFS_WFLAG, 8'h00);
         mcmd <= 1'b0;
         want_req(5'h00);
      end
      dtc <= 1'b1;
      @(posedge mclk);
      sdt <= 1'b1;
      @(posedge mclk);
      sdt <= 1'b0;
      want_req(5'h08);
      rd_reg(EIE_OFS_RFLAG, 8'hb0);
      wr_reg(EIE_OFS_ENABLE, 8'h00);
      want_req(5'h00);
      // Selected edges on pins not designated for interrupts set nothing
      des <= 1'b0;
      pins(1'b1);
      pins(1'b0);
      want_req(5'h00);
      rd_reg(EIE_OFS_RFLAG, 8'hb0);
      rd_reg(EIE_OFS_WFLAG, 8'hc0);
      wr_reg(EIE_OFS_IMASK, 8'h0f);
      want_req(5'h10);
      rd_reg(EIE_OFS_ISTAT, 8'h0f);
      want_req(5'h00);
      rd_reg(EIE_OFS_ISTAT, 8'h00);
      stop_test();
   end
endmodule // eie_top_bench
